// ==== verilog/ccpu_cfg.svh ====
// Offsets, field positions, mode codes and reset values of the capture/compare/PWM block.
`ifndef CCPU_CFG_SVH
`define CCPU_CFG_SVH
`define CCPU_UNITS 5
`define CCPU_AW 12
`define CCPU_UNIT_STRIDE 12'h010
`define CCPU_OFF_CTRL 12'h000
`define CCPU_OFF_LOW 12'h004
`define CCPU_OFF_HIGH 12'h008
`define CCPU_OFF_ROUTE 12'h050
`define CCPU_OFF_FLAG 12'h054
`define CCPU_CTRL_DUTY_HI 5
`define CCPU_CTRL_DUTY_LO 4
`define CCPU_CTRL_MODE_HI 3
`define CCPU_CTRL_RESET 6'h00
`define CCPU_DATA_RESET 16'h0000
`define CCPU_ROUTE_RESET 2'h0
`define CCPU_M_OFF 4'h0
`define CCPU_M_TOGGLE 4'h2
`define CCPU_M_CAP_FALL 4'h4
`define CCPU_M_CAP_RISE 4'h5
`define CCPU_M_CAP_4TH 4'h6
`define CCPU_M_CAP_16TH 4'h7
`define CCPU_M_SET_HIGH 4'h8
`define CCPU_M_SET_LOW 4'h9
`define CCPU_M_SOFT_INT 4'ha
`define CCPU_M_SPECIAL 4'hb
`define CCPU_PSC_4TH 4'h3
`define CCPU_PSC_16TH 4'hf
`define CCPU_TRIGGER_UNITS 2
`endif

// ==== verilog/ccpu_pkg.sv ====
// Types shared by the capture/compare/PWM block.
`default_nettype none
package ccpu_pkg;
  // Timer routing settings, in the order of the routing field values.
  typedef enum logic [1:0] {
    CCPU_ROUTE_ALL_LOW = 2'h0,
    CCPU_ROUTE_FIRST_LOW = 2'h1,
    CCPU_ROUTE_PAIR_LOW = 2'h2,
    CCPU_ROUTE_ALL_HIGH = 2'h3
  } ccpu_route_e;

  // Complete state of the block, registered as one word.
  typedef struct packed {
    logic [4:0][5:0] ctrl;
    logic [4:0][15:0] data;
    logic [4:0] flag;
    logic [1:0] route;
    logic [4:0][3:0] psc;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] prev;
    logic [4:0] latch;
    logic [4:0] match_d;
    logic [31:0] prdata;
    logic timer_one_rst;
    logic timer_three_rst;
  } ccpu_state_s;
endpackage
`default_nettype wire

// ==== verilog/ccpu_top.sv ====
// Five capture/compare/PWM units with timer routing behind an APB register slave.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_cfg.svh"

module ccpu_top
  import ccpu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] unit_pin_in,
  output logic [4:0] unit_pin_out,
  output logic [4:0] unit_pin_oe_n,
  input wire logic [4:0] port_direction,
  input wire logic [15:0] timer_one_value,
  input wire logic [15:0] timer_three_value,
  input wire logic timer_two_match,
  input wire logic timer_four_match,
  output logic timer_one_reset,
  output logic timer_three_reset,
  output logic [4:0] unit_event_flag,
  output logic [4:0] pwm_time_base,
  output logic [49:0] pwm_duty
);

  ccpu_state_s r;
  ccpu_state_s n;
  logic [4:0] sel_high;
  logic [4:0] cap_ev;
  logic [4:0] match_ev;
  logic [4:0] is_cap;
  logic [4:0] is_pwm;
  logic [4:0] is_cmp;
  logic [4:0][15:0] tval;
  logic setup_rd;
  logic wr_take;
  logic hit;
  logic [31:0] rd_val;

  // Bus phases: reads are sampled in the setup cycle, writes land at the access edge.
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_take = psel && penable && pwrite;

  // Every assertion below runs on the bus clock and is muted while reset is applied.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Address decode and read mux; unmapped addresses read zero and flag an error.
  always_comb
  begin
    hit = 1'b0;
    rd_val = 32'h0000_0000;
    if (paddr == `CCPU_OFF_ROUTE)
    begin
      hit = 1'b1;
      rd_val = {30'h0000_0000, r.route};
    end
    else if (paddr == `CCPU_OFF_FLAG)
    begin
      hit = 1'b1;
      rd_val = {27'h000_0000, r.flag};
    end
    else
    begin
      for (int u = 0; u < `CCPU_UNITS; u++)
      begin
        if (paddr == 12'(u) * `CCPU_UNIT_STRIDE + `CCPU_OFF_CTRL)
        begin
          hit = 1'b1;
          rd_val = {26'h000_0000, r.ctrl[u]};
        end
        else if (paddr == 12'(u) * `CCPU_UNIT_STRIDE + `CCPU_OFF_LOW)
        begin
          hit = 1'b1;
          rd_val = {24'h00_0000, r.data[u][7:0]};
        end
        else if (paddr == 12'(u) * `CCPU_UNIT_STRIDE + `CCPU_OFF_HIGH)
        begin
          hit = 1'b1;
          rd_val = {24'h00_0000, r.data[u][15:8]};
        end
      end
    end
  end

  // Per-unit mode classes and timer selection.
  always_comb
  begin
    for (int i = 0; i < `CCPU_UNITS; i++)
    begin
      is_cap[i] = r.ctrl[i][3:2] == 2'b01;
      is_pwm[i] = r.ctrl[i][3:2] == 2'b11;
      is_cmp[i] = (r.ctrl[i][3:0] == `CCPU_M_TOGGLE) || (r.ctrl[i][3:2] == 2'b10);
      // Routing decides whether a unit sits on the low or the high timer pair.
      case (ccpu_route_e'(r.route))
        CCPU_ROUTE_ALL_LOW: sel_high[i] = 1'b0;
        CCPU_ROUTE_FIRST_LOW: sel_high[i] = (i >= 1);
        CCPU_ROUTE_PAIR_LOW: sel_high[i] = (i >= 2);
        default: sel_high[i] = 1'b1;
      endcase
      tval[i] = sel_high[i] ? timer_three_value : timer_one_value;
    end
  end

  // Next state: software writes first, hardware events after so that they win.
  always_comb
  begin
    n = r;
    n.timer_one_rst = 1'b0;
    n.timer_three_rst = 1'b0;
    cap_ev = 5'h00;
    match_ev = 5'h00;
    if (setup_rd)
    begin
      n.prdata = rd_val;
    end
    if (wr_take)
    begin
      if (paddr == `CCPU_OFF_ROUTE)
      begin
        n.route = pwdata[1:0];
      end
      else if (paddr == `CCPU_OFF_FLAG)
      begin
        n.flag = r.flag & ~pwdata[4:0];
      end
      for (int u = 0; u < `CCPU_UNITS; u++)
      begin
        if (paddr == 12'(u) * `CCPU_UNIT_STRIDE + `CCPU_OFF_CTRL)
        begin
          n.ctrl[u] = pwdata[5:0];
          // Entering a forcing compare mode presets the output latch.
          if (pwdata[3:0] == `CCPU_M_SET_HIGH)
          begin
            n.latch[u] = 1'b0;
          end
          else if (pwdata[3:0] == `CCPU_M_SET_LOW)
          begin
            n.latch[u] = 1'b1;
          end
        end
        else if (paddr == 12'(u) * `CCPU_UNIT_STRIDE + `CCPU_OFF_LOW)
        begin
          n.data[u][7:0] = pwdata[7:0];
        end
        else if (paddr == 12'(u) * `CCPU_UNIT_STRIDE + `CCPU_OFF_HIGH)
        begin
          n.data[u][15:8] = pwdata[7:0];
        end
      end
    end
    for (int i = 0; i < `CCPU_UNITS; i++)
    begin
      // Two-stage synchroniser, then a third stage kept for edge detection.
      n.sync1[i] = unit_pin_in[i];
      n.sync2[i] = r.sync1[i];
      n.prev[i] = r.sync2[i];
      // Edge selection and prescaling; the count only lives in capture modes.
      if (!is_cap[i])
      begin
        n.psc[i] = 4'h0;
      end
      else if (r.sync2[i] && !r.prev[i])
      begin
        case (r.ctrl[i][3:0])
          `CCPU_M_CAP_RISE: cap_ev[i] = 1'b1;
          `CCPU_M_CAP_4TH:
          begin
            cap_ev[i] = r.psc[i] == `CCPU_PSC_4TH;
            n.psc[i] = cap_ev[i] ? 4'h0 : r.psc[i] + 4'h1;
          end
          `CCPU_M_CAP_16TH:
          begin
            cap_ev[i] = r.psc[i] == `CCPU_PSC_16TH;
            n.psc[i] = r.psc[i] + 4'h1;
          end
          default: cap_ev[i] = 1'b0;
        endcase
      end
      else if (!r.sync2[i] && r.prev[i])
      begin
        cap_ev[i] = r.ctrl[i][3:0] == `CCPU_M_CAP_FALL;
      end
      // A capture overwrites whatever is held, read or not.
      if (cap_ev[i])
      begin
        n.data[i] = tval[i];
        n.flag[i] = 1'b1;
      end
      // Compare fires once per equality so a stopped timer cannot retrigger.
      n.match_d[i] = is_cmp[i] && (r.data[i] == tval[i]);
      match_ev[i] = n.match_d[i] && !r.match_d[i];
      if (match_ev[i])
      begin
        n.flag[i] = 1'b1;
        case (r.ctrl[i][3:0])
          `CCPU_M_TOGGLE: n.latch[i] = !r.latch[i];
          `CCPU_M_SET_HIGH: n.latch[i] = 1'b1;
          `CCPU_M_SET_LOW: n.latch[i] = 1'b0;
          `CCPU_M_SPECIAL:
          begin
            // Only the first two units carry the timer reset trigger.
            if (i < `CCPU_TRIGGER_UNITS)
            begin
              n.timer_one_rst = n.timer_one_rst || !sel_high[i];
              n.timer_three_rst = n.timer_three_rst || sel_high[i];
            end
          end
          default: n.latch[i] = r.latch[i];
        endcase
      end
      // Off mode clears the unit's internal state and output latch. The next control
      // value is tested, so a write that leaves off with a forcing mode keeps its preset
      // instead of having it wiped by the off state that it is leaving.
      if (n.ctrl[i][3:0] == `CCPU_M_OFF)
      begin
        n.match_d[i] = 1'b0;
        n.latch[i] = 1'b0;
      end
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
    end
    else if (clk_en)
    begin
      r <= n;
    end
  end

  // Bus answers: zero wait states, error on unmapped addresses.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = r.prdata;
  assign timer_one_reset = r.timer_one_rst;
  assign timer_three_reset = r.timer_three_rst;
  assign unit_event_flag = r.flag;

  // Per-unit outputs. The pin is driven only in compare or PWM modes with the
  // direction bit cleared; the special trigger of units three to five keeps it as port I/O.
  genvar g;
  generate
    for (g = 0; g < `CCPU_UNITS; g++)
    begin : g_unit
      logic drives;
      assign drives = (is_cmp[g] || is_pwm[g]) && !port_direction[g] &&
        !(g >= `CCPU_TRIGGER_UNITS && r.ctrl[g][3:0] == `CCPU_M_SPECIAL);
      assign unit_pin_out[g] = r.latch[g];
      assign unit_pin_oe_n[g] = !drives;
      // The fourth timer's match goes nowhere but here.
      assign pwm_time_base[g] = is_pwm[g] &&
        (sel_high[g] ? timer_four_match : timer_two_match);
      assign pwm_duty[g*10 +: 10] = {r.data[g][7:0], r.ctrl[g][5:4]};

      // Capture path: the value, the flag and the prescaler.
      a_capture_copy: assert property (clk_en && cap_ev[g] |=> r.data[g] == $past(tval[g]))
        else $error("capture did not load the timer value");
      a_capture_flag: assert property (clk_en && cap_ev[g] |=> r.flag[g])
        else $error("capture did not set the event flag");
      a_psc_clear: assert property (clk_en && !is_cap[g] |=> r.psc[g] == 4'h0)
        else $error("prescaler not cleared outside capture");
      a_cap_mode_only: assert property (cap_ev[g] |-> is_cap[g])
        else $error("capture event outside a capture mode");
      a_sync_stage: assert property (clk_en |=> r.sync2[g] == $past(r.sync1[g]))
        else $error("pin synchroniser skipped a stage");
      // Compare path: each match action on the latch and the flag.
      a_toggle_match: assert property (clk_en && match_ev[g] &&
        r.ctrl[g][3:0] == `CCPU_M_TOGGLE |=> r.latch[g] != $past(r.latch[g]))
        else $error("toggle on match missing");
      a_force_high: assert property (clk_en && match_ev[g] &&
        r.ctrl[g][3:0] == `CCPU_M_SET_HIGH |=> r.latch[g] && r.flag[g])
        else $error("force high on match missing");
      a_force_low: assert property (clk_en && match_ev[g] &&
        r.ctrl[g][3:0] == `CCPU_M_SET_LOW |=> !r.latch[g] && r.flag[g])
        else $error("force low on match missing");
      a_softint_pin: assert property (clk_en && match_ev[g] &&
        r.ctrl[g][3:0] == `CCPU_M_SOFT_INT && !wr_take |=> $stable(r.latch[g]) && r.flag[g])
        else $error("software interrupt mode disturbed the pin");
      a_match_flag: assert property (clk_en && match_ev[g] |=> r.flag[g])
        else $error("compare match did not set the event flag");
      // The flag only falls when software writes a one to its bit.
      a_flag_sticky: assert property (clk_en && r.flag[g] &&
        !(wr_take && paddr == `CCPU_OFF_FLAG && pwdata[g]) |=> r.flag[g])
        else $error("event flag dropped without a software clear");
      a_duty_bits: assert property (is_pwm[g] && $stable(r.data[g]) && $stable(r.ctrl[g])
        |-> $stable(pwm_duty[g*10 +: 10]))
        else $error("duty changed without a register change");
      a_base_idle: assert property (!is_pwm[g] |-> !pwm_time_base[g])
        else $error("time base tick outside PWM mode");
      // A disabled unit neither holds latch or match state nor raises events.
      a_off_pin_low: assert property (clk_en && r.ctrl[g][3:0] == `CCPU_M_OFF && !wr_take
        |=> !r.latch[g] && !r.match_d[g])
        else $error("disabled unit kept internal state");
      a_off_no_event: assert property (r.ctrl[g][3:0] == `CCPU_M_OFF |->
        !cap_ev[g] && !match_ev[g])
        else $error("disabled unit produced an event");
      if (g < `CCPU_TRIGGER_UNITS)
      begin : g_trig
        a_special_reset: assert property (clk_en && match_ev[g] &&
          r.ctrl[g][3:0] == `CCPU_M_SPECIAL |=> timer_one_reset || timer_three_reset)
          else $error("special trigger did not reset a timer");
        a_trig_low: assert property (clk_en && match_ev[g] && !sel_high[g] &&
          r.ctrl[g][3:0] == `CCPU_M_SPECIAL |=> timer_one_reset)
          else $error("special trigger missed the low timer");
      end
      else
      begin : g_plain
        // Units without the trigger keep the pin as port I/O in the special mode.
        a_plain_pin: assert property (r.ctrl[g][3:0] == `CCPU_M_SPECIAL |->
          unit_pin_oe_n[g])
          else $error("unit without trigger drove its pin in special mode");
      end
    end
  endgenerate

  // Routing settings, one check for each setting.
  a_route_first: assert property (@(posedge pclk) disable iff (!presetn)
    r.route == 2'h0 |-> sel_high == 5'h00)
    else $error("routing setting one selected a high timer");
  a_route_second: assert property (r.route == 2'h1 |-> sel_high == 5'h1e)
    else $error("routing setting two picked the wrong timers");
  a_route_third: assert property (r.route == 2'h2 |-> sel_high == 5'h1c)
    else $error("routing setting three picked the wrong timers");
  a_route_fourth: assert property (r.route == 2'h3 |-> sel_high == 5'h1f)
    else $error("routing setting four selected a low timer");
  // Read data only moves at a read setup, so a slow master still sees it in access.
  a_prdata_hold: assert property (!(clk_en && setup_rd) |=> $stable(prdata))
    else $error("read data changed outside a read setup");
  a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && setup_rd && paddr == `CCPU_OFF_CTRL |=> prdata[7:6] == 2'b00)
    else $error("control bits seven and six read nonzero");

endmodule
`default_nettype wire

// ==== bench/ccpu_far_model.sv ====
// Far-side model: the four shared timers and the five unit pins.
`timescale 1ns/1ps
`default_nettype none
module ccpu_far_model
#(
  parameter logic [15:0] T1_START = 16'h1234,
  parameter logic [15:0] T3_START = 16'hab00
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic load,
  input wire logic timer_one_reset,
  input wire logic timer_three_reset,
  output logic [15:0] timer_one_value,
  output logic [15:0] timer_three_value,
  output logic timer_two_match,
  output logic timer_four_match,
  output logic [4:0] pins,
  output int resets_seen
);
  logic [2:0] tick;
  initial pins = 5'h00;
  // Timers step on the system clock only, never asynchronously.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_one_value <= T1_START;
      timer_three_value <= T3_START;
      tick <= 3'h0;
      resets_seen <= 0;
    end
    else
    begin
      tick <= tick + 3'h1;
      if (load)
      begin
        timer_one_value <= T1_START;
        timer_three_value <= T3_START;
      end
      else if (run)
      begin
        timer_one_value <= timer_one_reset ? 16'h0000 : timer_one_value + 16'h0001;
        timer_three_value <= timer_three_reset ? 16'h0000 : timer_three_value + 16'h0001;
      end
      if (timer_one_reset || timer_three_reset)
        resets_seen <= resets_seen + 1;
    end
  end
  // Two PWM bases at different rates, so the routing shows in the tick count.
  assign timer_two_match = (tick[1:0] == 2'h0);
  assign timer_four_match = (tick == 3'h0);
  // One slow pin pulse; the pin is an input while capturing.
  task automatic pulse(input int u);
    @(posedge pclk);
    pins[u] <= 1'b1;
    repeat (6) @(posedge pclk);
    pins[u] <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== bench/ccp_capture_compare_pwm_tb.sv ====
// Self-checking bench for the capture/compare/PWM block over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_cfg.svh"
module ccp_capture_compare_pwm_tb;
  import ccpu_pkg::*;
  localparam logic [15:0] T1_START = 16'h1234;
  localparam logic [15:0] T3_START = 16'hab00;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, bad, r1, r3, m2, m4, run = 1'b0, load = 1'b0;
  logic [4:0] pin_out, oe_n, pins, flags, base, dir = 5'h1f;
  logic [15:0] t1, t3;
  logic ce = 1'b1;
  logic [49:0] duty;
  int n_fail = 0, checks_done = 0, rs;
  int cu[6] = '{0, 0, 0, 0, 0, 2};
  logic [3:0] cm[6] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'h2, 4'hb};
  logic p0[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic p1[6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  ccpu_top i_ccpu_top (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unit_pin_in(pins), .unit_pin_out(pin_out),
    .unit_pin_oe_n(oe_n), .port_direction(dir), .timer_one_value(t1),
    .timer_three_value(t3), .timer_two_match(m2), .timer_four_match(m4),
    .timer_one_reset(r1), .timer_three_reset(r3), .unit_event_flag(flags),
    .pwm_time_base(base), .pwm_duty(duty));
  ccpu_far_model #(.T1_START(T1_START), .T3_START(T3_START)) i_ccpu_far_model (
    .pclk(pclk), .presetn(presetn), .run(run), .load(load), .timer_one_reset(r1),
    .timer_three_reset(r3), .timer_one_value(t1), .timer_three_value(t3),
    .timer_two_match(m2), .timer_four_match(m4), .pins(pins), .resets_seen(rs));
  // Clock at 50 MHz.
  initial
  begin
    forever #10 pclk = ~pclk;
  end
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    bad = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [11:0] ua(input int u, input logic [11:0] off);
    return 12'(u * 16) + off;
  endfunction
  // Counts time-base ticks of one unit over 64 cycles.
  task automatic count_base(input int u, input int exp);
    int c = 0;
    repeat (64)
    begin
      @(negedge pclk);
      if (base[u] === 1'b1)
        c++;
    end
    chk(c, exp);
  endtask
  task automatic report_and_stop;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the fewer than two thousand cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ua(0, `CCPU_OFF_CTRL), 32'h0);
    rdc(`CCPU_OFF_FLAG, 32'h0);
    // With the clock enable low a write must not land.
    ce <= 1'b0;
    apb(1'b1, ua(3, `CCPU_OFF_LOW), 32'h77);
    ce <= 1'b1;
    rdc(ua(3, `CCPU_OFF_LOW), 32'h0);
    apb(1'b1, ua(4, `CCPU_OFF_CTRL), 32'hff);
    rdc(ua(4, `CCPU_OFF_CTRL), 32'h3f);
    apb(1'b1, ua(4, `CCPU_OFF_LOW), 32'ha5);
    apb(1'b1, ua(4, `CCPU_OFF_HIGH), 32'h5a);
    rdc(ua(4, `CCPU_OFF_HIGH), 32'h5a);
    chk({22'h0, duty[49:40]}, 32'h297);
    rdc(12'h060, 32'h0);
    chk({31'h0, bad}, 32'h1);
    // PWM bases: timer two ticks every 4 cycles, timer four every 8.
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, `CCPU_OFF_ROUTE, r);
      count_base(4, (r == 0) ? 16 : 8);
    end
    apb(1'b1, `CCPU_OFF_ROUTE, 32'h0);
    apb(1'b1, ua(4, `CCPU_OFF_CTRL), 32'h0);
    // Capture modes; a stray edge before the off write must not count.
    for (int m = 4; m < 8; m++)
    begin
      apb(1'b1, ua(0, `CCPU_OFF_CTRL), m);
      i_ccpu_far_model.pulse(0);
      apb(1'b1, ua(0, `CCPU_OFF_CTRL), 32'h0);
      apb(1'b1, ua(0, `CCPU_OFF_CTRL), m);
      apb(1'b1, `CCPU_OFF_FLAG, 32'h1f);
      repeat ((m == 6) ? 3 : (m == 7) ? 15 : 0) i_ccpu_far_model.pulse(0);
      rdc(`CCPU_OFF_FLAG, 32'h0);
      i_ccpu_far_model.pulse(0);
      rdc(`CCPU_OFF_FLAG, 32'h1);
      rdc(ua(0, `CCPU_OFF_LOW), {24'h0, T1_START[7:0]});
      apb(1'b1, ua(0, `CCPU_OFF_CTRL), 32'h0);
    end
    // Routing of the capture time base for units one to three.
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, `CCPU_OFF_ROUTE, r);
      for (int u = 0; u < 3; u++)
      begin
        apb(1'b1, ua(u, `CCPU_OFF_CTRL), 32'h5);
        apb(1'b1, `CCPU_OFF_FLAG, 32'h1f);
        i_ccpu_far_model.pulse(u);
        rdc(`CCPU_OFF_FLAG, 32'h1 << u);
        if (r == 0 || (r == 1 && u == 0) || (r == 2 && u < 2))
          rdc(ua(u, `CCPU_OFF_HIGH), {24'h0, T1_START[15:8]});
        else
          rdc(ua(u, `CCPU_OFF_HIGH), {24'h0, T3_START[15:8]});
        apb(1'b1, ua(u, `CCPU_OFF_CTRL), 32'h0);
      end
    end
    // Compare modes with the pin driven, except unit three in the special mode; match comes 12 counts after load.
    apb(1'b1, `CCPU_OFF_ROUTE, 32'h0);
    dir <= 5'h00;
    for (int i = 0; i < 6; i++)
    begin
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      apb(1'b1, ua(cu[i], `CCPU_OFF_LOW), 32'h40);
      apb(1'b1, ua(cu[i], `CCPU_OFF_HIGH), 32'h12);
      apb(1'b1, `CCPU_OFF_FLAG, 32'h1f);
      apb(1'b1, ua(cu[i], `CCPU_OFF_CTRL), cm[i]);
      @(posedge pclk);
      chk(pin_out[cu[i]], p0[i]);
      chk(oe_n[cu[i]], cu[i] == 2);
      run <= 1'b1;
      repeat (40) @(posedge pclk);
      run <= 1'b0;
      chk(pin_out[cu[i]], p1[i]);
      chk(rs, (i > 2) ? 1 : 0);
      chk({27'h0, flags}, 32'h1 << cu[i]);
      rdc(`CCPU_OFF_FLAG, 32'h1 << cu[i]);
      apb(1'b1, ua(cu[i], `CCPU_OFF_CTRL), 32'h0);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
